/* common/drpm_pkg.sv */
// package for the rank and port mapping block: defaults, widths, states
// assumes one controller clock domain; no register bus
package drpm_pkg;
    // interface address is 36 bits, bit 0 most significant on the wire
    localparam int DRPM_IFACE_ADDR_W = 36;
    localparam int DRPM_BYTE_W = 8;
    localparam int DRPM_BEATS = 2;
    localparam int DRPM_MAX_RANKS = 4;
    localparam int DRPM_DEF_RANKS = 4;
    localparam int DRPM_DEF_DWIDTH = 32;
    localparam int DRPM_DEF_COL_W = 10;
    localparam int DRPM_DEF_ROW_W = 13;
    localparam int DRPM_DEF_BANK_W = 2;
    localparam int DRPM_DEF_CLK_PAIRS = 1;
    localparam logic [35:0] DRPM_DEF_WIN_BASE = 36'h0_0000_0000;
    localparam logic [35:0] DRPM_DEF_WIN_TOP = 36'h0_3FFF_FFFF;
    localparam logic [0:0] DRPM_CKE_RESET = 1'h0;

    typedef enum logic [2:0] {
        DRPM_IDLE = 3'b001,
        DRPM_BEAT0 = 3'b010,
        DRPM_BEAT1 = 3'b100
    } drpm_state_t;

    // request kind travelling with the accepted access
    typedef struct packed {
        logic valid;
        logic write;
        logic hit;
    } drpm_req_t;
endpackage

/* rtl/drpm_addr_map.sv */
// address split for the rank and port mapping block: window hit, rank,
// bank, row and column fields from a little-endian request address
// assumes the window is a power-of-two size on an aligned base
`timescale 1ns/1ps
`default_nettype none
module drpm_addr_map import drpm_pkg::*; #(
    parameter int RANKS = DRPM_DEF_RANKS,
    parameter int DWIDTH = DRPM_DEF_DWIDTH,
    parameter int COL_W = DRPM_DEF_COL_W,
    parameter int ROW_W = DRPM_DEF_ROW_W,
    parameter int BANK_W = DRPM_DEF_BANK_W,
    parameter logic [35:0] WIN_BASE = DRPM_DEF_WIN_BASE,
    parameter logic [35:0] WIN_TOP = DRPM_DEF_WIN_TOP
) (
    input wire logic [DRPM_IFACE_ADDR_W-1:0] addr,
    output logic hit,
    output logic [RANKS-1:0] rank_onehot,
    output logic [BANK_W-1:0] bank,
    output logic [ROW_W-1:0] row,
    output logic [COL_W-1:0] col
);
    localparam int OFFSET = $clog2(DWIDTH / DRPM_BYTE_W);
    localparam logic [36:0] WIN_SIZE = {1'b0, WIN_TOP - WIN_BASE} + 37'h1;
    localparam int WIN_BITS = $clog2(WIN_SIZE);
    localparam int RANK_BITS = (RANKS > 1) ? $clog2(RANKS) : 1;
    localparam int RANK_SHIFT = (RANKS > 1) ? WIN_BITS - RANK_BITS : 0;

    logic [35:0] rel;
    logic [RANK_BITS-1:0] idx;

    always_comb begin
        rel = addr - WIN_BASE;
        // column, row, bank upward from the byte offset
        col = addr[OFFSET +: COL_W];
        row = addr[OFFSET + COL_W +: ROW_W];
        bank = addr[OFFSET + COL_W + ROW_W +: BANK_W];
        hit = (addr >= WIN_BASE) && (addr <= WIN_TOP);
        // equal contiguous ranges, rank 0 at the base
        idx = (RANKS > 1) ? rel[RANK_SHIFT +: RANK_BITS] : '0;
        rank_onehot = '0;
        // outside the window no rank is chosen
        if (hit) begin
            rank_onehot[idx] = 1'b1;
        end
    end
endmodule // drpm_addr_map
`default_nettype wire

/* rtl/drpm_rank_port_map.sv */
// rank and port mapping for a DDR2 controller: takes one request from the
// processor memory interface, drives rank selects, bank/row/column, two
// data beats with masks and strobes, and returns two read beats as one word
// assumes the requester holds its request until ready and one clock domain
//
// Contract
// - one to four ranks, each with chip select, clock enable, termination
// - window split into equal contiguous rank ranges, rank 0 at base
// - every rank range is reachable from every requesting port
// - each memory access is two, four or eight bytes by width setting
// - interface data uses big-endian numbering, bit 0 most significant
// - memory side little-endian; bit order reversed across the boundary
// - interface data buses are twice memory width, two beats per word
// - data mask driven from byte enables; disabled bytes masked on write
// - bank address and strobes generated here from the 36-bit address
// - select, clock enable and range widths scale with rank count
// - memory data pin width equals the data width parameter
// - strobe pair count equals the strobe width parameter
// - column, row, bank taken upward above log2(width/8) byte offset
`timescale 1ns/1ps
`default_nettype none
module drpm_rank_port_map import drpm_pkg::*; #(
    parameter int RANKS = DRPM_DEF_RANKS,
    parameter int DWIDTH = DRPM_DEF_DWIDTH,
    parameter int STROBE_W = DRPM_DEF_DWIDTH / DRPM_BYTE_W,
    parameter int MASK_W = DRPM_DEF_DWIDTH / DRPM_BYTE_W,
    parameter int COL_W = DRPM_DEF_COL_W,
    parameter int ROW_W = DRPM_DEF_ROW_W,
    parameter int BANK_W = DRPM_DEF_BANK_W,
    parameter int CLK_PAIRS = DRPM_DEF_CLK_PAIRS,
    parameter logic [35:0] WIN_BASE = DRPM_DEF_WIN_BASE,
    parameter logic [35:0] WIN_TOP = DRPM_DEF_WIN_TOP
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic iface_req_valid,
    input wire logic iface_req_write,
    input wire logic [0:DRPM_IFACE_ADDR_W-1] iface_request_address,
    input wire logic [0:2*DWIDTH-1] iface_write_data,
    input wire logic [0:2*DWIDTH/DRPM_BYTE_W-1] iface_byte_lane_enables,
    output logic iface_req_ready,
    output logic iface_req_miss,
    output logic [0:2*DWIDTH-1] iface_read_data,
    output logic iface_read_valid,
    output logic [RANKS-1:0] rank_select_n,
    output logic [RANKS-1:0] rank_clk_en,
    output logic [RANKS-1:0] rank_termination_ctl,
    output logic [BANK_W-1:0] mem_bank_select,
    output logic [ROW_W-1:0] mem_row,
    output logic [COL_W-1:0] mem_col,
    output logic mem_write_en,
    input wire logic [DWIDTH-1:0] mem_dq_in,
    output logic [DWIDTH-1:0] mem_dq_out,
    output logic mem_dq_oe,
    output logic [MASK_W-1:0] mem_mask_pins,
    output logic [STROBE_W-1:0] mem_strobe_p_out,
    output logic [STROBE_W-1:0] mem_strobe_n_out,
    output logic mem_strobe_oe,
    output logic [CLK_PAIRS-1:0] mem_clk_p,
    output logic [CLK_PAIRS-1:0] mem_clk_n
);
    localparam int WORD_W = 2 * DWIDTH;
    localparam int LANES = WORD_W / DRPM_BYTE_W;
    localparam int BYTES_PER_BEAT = DWIDTH / DRPM_BYTE_W;

    typedef struct packed {
        drpm_state_t state;
        drpm_req_t req;
        logic ready;
        logic miss;
        logic [WORD_W-1:0] wdata;
        logic [LANES-1:0] lane_en;
        logic [WORD_W-1:0] rdata;
        logic rvalid;
        logic [RANKS-1:0] cs_n;
        logic [RANKS-1:0] cke;
        logic [RANKS-1:0] odt;
        logic [BANK_W-1:0] bank;
        logic [ROW_W-1:0] row;
        logic [COL_W-1:0] col;
        logic wr_en;
        logic [DWIDTH-1:0] dq;
        logic dq_oe;
        logic [MASK_W-1:0] mask;
        logic strobe;
        logic strobe_n;
        logic strobe_oe;
        logic clk_phase;
        logic clk_n;
    } drpm_regs_t;

    drpm_regs_t cur;
    drpm_regs_t next_cur;

    logic [DRPM_IFACE_ADDR_W-1:0] addr_le;
    logic [WORD_W-1:0] wdata_le;
    logic [LANES-1:0] lanes_le;
    logic map_hit;
    logic [RANKS-1:0] map_rank;
    logic [BANK_W-1:0] map_bank;
    logic [ROW_W-1:0] map_row;
    logic [COL_W-1:0] map_col;

    // mask pins cover one byte each; wider groupings are not supported
    function automatic logic [MASK_W-1:0] beat_mask(
        input logic [BYTES_PER_BEAT-1:0] en
    );
        beat_mask = MASK_W'(~en);
    endfunction

    // positional copy: big-endian bit 0 lands on little-endian msb
    assign addr_le = iface_request_address;
    assign wdata_le = iface_write_data;
    assign lanes_le = iface_byte_lane_enables;

    // one decoder serves every requester, so no port sees fewer ranks
    drpm_addr_map #(
        .RANKS(RANKS),
        .DWIDTH(DWIDTH),
        .COL_W(COL_W),
        .ROW_W(ROW_W),
        .BANK_W(BANK_W),
        .WIN_BASE(WIN_BASE),
        .WIN_TOP(WIN_TOP)
    ) u_map (
        .addr(addr_le),
        .hit(map_hit),
        .rank_onehot(map_rank),
        .bank(map_bank),
        .row(map_row),
        .col(map_col)
    );

    always_comb begin
        next_cur = cur;
        next_cur.miss = 1'b0;
        next_cur.rvalid = 1'b0;
        next_cur.clk_phase = ~cur.clk_phase;
        // clock enables held high for all ranks once out of reset
        next_cur.cke = '1;
        case (cur.state)
            DRPM_IDLE: begin
                next_cur.cs_n = '1;
                next_cur.odt = '0;
                next_cur.wr_en = 1'b0;
                next_cur.dq_oe = 1'b0;
                next_cur.strobe_oe = 1'b0;
                next_cur.mask = '0;
                if (iface_req_valid && cur.ready) begin
                    next_cur.req = '{valid: 1'b1, write: iface_req_write,
                                     hit: map_hit};
                    next_cur.miss = ~map_hit;
                    next_cur.wdata = wdata_le;
                    next_cur.lane_en = lanes_le;
                    next_cur.bank = map_bank;
                    next_cur.row = map_row;
                    next_cur.col = map_col;
                    if (map_hit) begin
                        next_cur.ready = 1'b0;
                        next_cur.state = DRPM_BEAT0;
                        next_cur.cs_n = ~map_rank;
                        next_cur.odt = iface_req_write ? map_rank : '0;
                        next_cur.wr_en = iface_req_write;
                        // upper half of the word is the first beat
                        next_cur.dq = wdata_le[WORD_W-1 -: DWIDTH];
                        next_cur.mask = beat_mask(
                            lanes_le[LANES-1 -: BYTES_PER_BEAT]);
                        next_cur.dq_oe = iface_req_write;
                        next_cur.strobe_oe = iface_req_write;
                        next_cur.strobe = 1'b1;
                    end
                end
            end
            DRPM_BEAT0: begin
                next_cur.state = DRPM_BEAT1;
                next_cur.dq = cur.wdata[DWIDTH-1:0];
                next_cur.mask = beat_mask(
                    cur.lane_en[BYTES_PER_BEAT-1:0]);
                next_cur.strobe = 1'b0;
                next_cur.rdata[WORD_W-1 -: DWIDTH] = mem_dq_in;
            end
            DRPM_BEAT1: begin
                next_cur.state = DRPM_IDLE;
                next_cur.ready = 1'b1;
                next_cur.cs_n = '1;
                next_cur.odt = '0;
                next_cur.wr_en = 1'b0;
                next_cur.dq_oe = 1'b0;
                next_cur.strobe_oe = 1'b0;
                next_cur.mask = '0;
                next_cur.req.valid = 1'b0;
                next_cur.rdata[DWIDTH-1:0] = mem_dq_in;
                next_cur.rvalid = ~cur.req.write;
            end
            default: begin
                next_cur.state = DRPM_IDLE;
                next_cur.ready = 1'b1;
                next_cur.cs_n = '1;
            end
        endcase
        // complements registered too, so every pin leaves a flip-flop
        next_cur.strobe_n = ~next_cur.strobe;
        next_cur.clk_n = ~next_cur.clk_phase;
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            cur <= '0;
            cur.state <= DRPM_IDLE;
            cur.ready <= 1'b1;
            cur.cs_n <= '1;
            cur.cke <= {RANKS{DRPM_CKE_RESET}};
            cur.strobe_n <= 1'b1;
            cur.clk_n <= 1'b1;
        end else begin
            cur <= next_cur;
        end
    end

    assign iface_req_ready = cur.ready;
    assign iface_req_miss = cur.miss;
    assign iface_read_data = cur.rdata;
    assign iface_read_valid = cur.rvalid;
    assign rank_select_n = cur.cs_n;
    assign rank_clk_en = cur.cke;
    assign rank_termination_ctl = cur.odt;
    assign mem_bank_select = cur.bank;
    assign mem_row = cur.row;
    assign mem_col = cur.col;
    assign mem_write_en = cur.wr_en;
    assign mem_dq_out = cur.dq;
    assign mem_dq_oe = cur.dq_oe;
    assign mem_mask_pins = cur.mask;
    assign mem_strobe_p_out = {STROBE_W{cur.strobe}};
    assign mem_strobe_n_out = {STROBE_W{cur.strobe_n}};
    assign mem_strobe_oe = cur.strobe_oe;
    assign mem_clk_p = {CLK_PAIRS{cur.clk_phase}};
    assign mem_clk_n = {CLK_PAIRS{cur.clk_n}};
endmodule // drpm_rank_port_map
`default_nettype wire

/* sim/drpm_rank_port_map_assertions.sv */
// checker for the rank and port mapping block, bound to its top ports
// assumes default parameters for the rank decode (window 0 to 0x3FFFFFFF)
`timescale 1ns/1ps
`default_nettype none
module drpm_rank_port_map_assertions import drpm_pkg::*; #(
    parameter int RANKS = DRPM_DEF_RANKS,
    parameter int MASK_W = 4,
    parameter int STROBE_W = 4
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic iface_req_valid,
    input wire logic [0:DRPM_IFACE_ADDR_W-1] iface_request_address,
    input wire logic iface_req_ready,
    input wire logic iface_req_miss,
    input wire logic iface_read_valid,
    input wire logic [RANKS-1:0] rank_select_n,
    input wire logic [RANKS-1:0] rank_clk_en,
    input wire logic [RANKS-1:0] rank_termination_ctl,
    input wire logic mem_write_en,
    input wire logic mem_dq_oe,
    input wire logic [MASK_W-1:0] mem_mask_pins,
    input wire logic [STROBE_W-1:0] mem_strobe_p_out,
    input wire logic [STROBE_W-1:0] mem_strobe_n_out
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    chk_cke_on: assert property (!reset |=> &rank_clk_en)
        else $error("clock enables not all on");
    chk_rank_map: assert property (
        iface_req_valid && iface_req_ready
        && iface_request_address[0:5] == 6'h0 |=> rank_select_n ==
        ~(RANKS'(1) << $past(iface_request_address[6:7])))
        else $error("wrong rank selected");
    chk_one_rank: assert property ($onehot0(~rank_select_n))
        else $error("more than one rank selected");
    chk_two_beats: assert property ($fell(&rank_select_n)
        |-> ##1 $stable(rank_select_n) ##1 (&rank_select_n))
        else $error("select not two beats");
    chk_ready_gap: assert property ($fell(iface_req_ready)
        |-> !(&rank_select_n) ##2 iface_req_ready)
        else $error("ready gap wrong");
    chk_read_ret: assert property (
        $fell(&rank_select_n) && !mem_write_en |-> ##2 iface_read_valid)
        else $error("read word late");
    chk_miss_quiet: assert property (iface_req_miss
        |-> &rank_select_n && iface_req_ready)
        else $error("miss selected a rank");
    chk_term_write: assert property (|rank_termination_ctl
        |-> mem_write_en && rank_termination_ctl == ~rank_select_n)
        else $error("termination off selected write rank");
    chk_mask_idle: assert property (&rank_select_n
        |-> mem_mask_pins == '0 && !mem_dq_oe)
        else $error("mask or drive outside beats");
    chk_strobe_pair: assert property ($fell(&rank_select_n)
        |-> mem_strobe_p_out == '1 && mem_strobe_n_out == '0)
        else $error("strobe pair wrong on first beat");
endmodule // drpm_rank_port_map_assertions
`default_nettype wire

/* sim/drpm_mem_model.sv */
// memory device stand-in: keeps written beats per rank, bank, row, column
// assumes level strobes per beat and one clock domain
`timescale 1ns/1ps
`default_nettype none
module drpm_mem_model (
    input wire logic core_clk,
    input wire logic [3:0] rank_select_n,
    input wire logic [24:0] addr,
    input wire logic mem_write_en,
    input wire logic [31:0] mem_dq_out,
    input wire logic [3:0] mem_mask_pins,
    input wire logic strobe,
    output logic [31:0] mem_dq_in
);
    logic [31:0] mem [logic [29:0]];
    logic [29:0] key;
    assign key = {rank_select_n, addr, strobe};
    initial mem_dq_in = 32'h0;
    always @(posedge core_clk) begin
        if (!(&rank_select_n) && mem_write_en) begin
            if (!mem.exists(key)) mem[key] = 32'h0;
            for (int i = 0; i < 4; i++) begin
                if (!mem_mask_pins[i]) begin
                    mem[key][8*i+:8] = mem_dq_out[8*i+:8];
                end
            end
        end
    end
    // released bus toggles so a stale sample never passes
    always @(negedge core_clk) begin
        if (!(&rank_select_n) && !mem_write_en && mem.exists(key))
            mem_dq_in <= mem[key];
        else
            mem_dq_in <= ~mem_dq_in;
    end
endmodule // drpm_mem_model
`default_nettype wire

/* sim/drpm_rank_port_map_tb.sv */
// testbench for the rank and port mapping block with default parameters
// assumes the memory stand-in answers reads from what was written
`timescale 1ns/1ps
`default_nettype none
module drpm_rank_port_map_tb;
    logic core_clk, reset, iface_req_valid, iface_req_write, iface_req_ready;
    logic iface_req_miss, iface_read_valid, mem_write_en, mem_dq_oe;
    logic mem_strobe_oe;
    logic [35:0] iface_request_address;
    logic [63:0] iface_write_data, iface_read_data;
    logic [7:0] iface_byte_lane_enables;
    logic [3:0] rank_select_n, rank_clk_en, rank_termination_ctl;
    logic [3:0] mem_mask_pins, mem_strobe_p_out, mem_strobe_n_out;
    logic [1:0] mem_bank_select;
    logic [12:0] mem_row;
    logic [9:0] mem_col;
    logic [31:0] mem_dq_in, mem_dq_out;
    logic [0:0] mem_clk_p, mem_clk_n;
    int errors, num_checks;
    // defaults keep the window an aligned power of two
    drpm_rank_port_map u_dut (
        .core_clk(core_clk),
        .reset(reset),
        .iface_req_valid(iface_req_valid),
        .iface_req_write(iface_req_write),
        .iface_request_address(iface_request_address),
        .iface_write_data(iface_write_data),
        .iface_byte_lane_enables(iface_byte_lane_enables),
        .iface_req_ready(iface_req_ready),
        .iface_req_miss(iface_req_miss),
        .iface_read_data(iface_read_data),
        .iface_read_valid(iface_read_valid),
        .rank_select_n(rank_select_n),
        .rank_clk_en(rank_clk_en),
        .rank_termination_ctl(rank_termination_ctl),
        .mem_bank_select(mem_bank_select),
        .mem_row(mem_row),
        .mem_col(mem_col),
        .mem_write_en(mem_write_en),
        .mem_dq_in(mem_dq_in),
        .mem_dq_out(mem_dq_out),
        .mem_dq_oe(mem_dq_oe),
        .mem_mask_pins(mem_mask_pins),
        .mem_strobe_p_out(mem_strobe_p_out),
        .mem_strobe_n_out(mem_strobe_n_out),
        .mem_strobe_oe(mem_strobe_oe),
        .mem_clk_p(mem_clk_p),
        .mem_clk_n(mem_clk_n)
    );
    drpm_mem_model u_mem (.core_clk(core_clk), .rank_select_n(rank_select_n),
        .addr({mem_bank_select, mem_row, mem_col}), .mem_write_en(mem_write_en),
        .mem_dq_out(mem_dq_out), .mem_mask_pins(mem_mask_pins),
        .strobe(mem_strobe_p_out[0]), .mem_dq_in(mem_dq_in));
    task automatic chk(string n, logic [63:0] e, logic [63:0] s);
        num_checks++;
        if (s !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // one request, entered and left at a falling edge
    task automatic access(input logic w, input logic [35:0] a,
            input logic [63:0] d, input logic [7:0] ln,
            output logic [63:0] rd);
        int n;
        logic ck;
        logic [3:0] sel;
        logic [7:0] mk;
        n = 0;
        ck = 1'b0;
        sel = ~(4'h1 << a[29:28]);
        mk = ~ln;
        rd = 64'h0;
        iface_req_valid = 1'b1;
        iface_req_write = w;
        iface_request_address = a;
        iface_write_data = d;
        iface_byte_lane_enables = ln;
        while (iface_req_ready !== 1'b1 && n < 20) begin
            @(negedge core_clk);
            n++;
        end
        if (iface_req_ready !== 1'b1) begin
            errors++;
            results();
        end
        @(negedge core_clk);
        iface_req_valid = 1'b0;
        if (a[35:30] != 6'h0) begin
            chk("miss", 2'h3, {iface_req_miss, iface_req_ready});
            chk("miss_cs", 4'hF, rank_select_n);
            // a cycle with valid low keeps back-to-back calls apart
            @(negedge core_clk);
            return;
        end
        for (int b = 0; b < 2; b++) begin
            if (b == 0) begin
                ck = mem_clk_p[0];
            end
            chk("select", sel, rank_select_n);
            chk("col", a[11:2], mem_col);
            chk("row", a[24:12], mem_row);
            chk("bank", a[26:25], mem_bank_select);
            chk("strobe_p", {4{!b}}, mem_strobe_p_out);
            chk("strobe_n", {4{b == 1}}, mem_strobe_n_out);
            chk("oe", {w, w}, {mem_strobe_oe, mem_dq_oe});
            chk("wr_en", w, mem_write_en);
            chk("clk_p", ck ^ (b == 1), mem_clk_p);
            chk("clk_n", !(ck ^ (b == 1)), mem_clk_n);
            if (w) begin
                chk("dq", b ? d[31:0] : d[63:32], mem_dq_out);
                chk("mask", b ? mk[3:0] : mk[7:4], mem_mask_pins);
                chk("term", sel ^ 4'hF, rank_termination_ctl);
            end else begin
                chk("term", 4'h0, rank_termination_ctl);
            end
            @(negedge core_clk);
        end
        chk("idle_cs", 4'hF, rank_select_n);
        chk("idle_oe", 1'b0, mem_dq_oe);
        chk("ready", 1'b1, iface_req_ready);
        chk("rvalid", !w, iface_read_valid);
        rd = iface_read_data;
    endtask
    task automatic t_ranks;
        logic [63:0] rd;
        logic [63:0] d;
        logic [35:0] a;
        for (int r = 0; r < 4; r++) begin
            a = {6'h0, 2'(r), 28'h5A3_C7E4};
            d = 64'h0123_4567_89AB_CDEF + 64'(r);
            access(1'b1, a, d, 8'hFF, rd);
            access(1'b0, a, 64'h0, 8'hFF, rd);
            chk("read", d, rd);
        end
        $display("ranks test done");
    endtask
    task automatic t_mask;
        logic [63:0] rd;
        logic [35:0] a;
        a = 36'h0_3FFF_FFF8;
        access(1'b1, a, 64'h1111_2222_3333_4444, 8'hFF, rd);
        access(1'b1, a, 64'hAAAA_BBBB_CCCC_DDDD, 8'hA5, rd);
        access(1'b0, a, 64'h0, 8'hFF, rd);
        chk("merge", 64'hAA11_BB22_33CC_44DD, rd);
        $display("mask test done");
    endtask
    task automatic t_miss;
        logic [63:0] rd;
        logic [63:0] d;
        d = 64'hFFFF_0000_FFFF_0000;
        access(1'b1, 36'h0_4000_0000, d, 8'hFF, rd);
        access(1'b0, 36'hF_0000_0000, 64'h0, 8'hFF, rd);
        $display("miss test done");
    endtask
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    initial begin
        errors = 0;
        num_checks = 0;
        reset = 1'b1;
        iface_req_valid = 1'b0;
        iface_req_write = 1'b0;
        iface_request_address = 36'h0;
        iface_write_data = 64'h0;
        iface_byte_lane_enables = 8'h0;
        repeat (8) @(negedge core_clk);
        chk("rst_ready", 1'b1, iface_req_ready);
        chk("rst_cs", 4'hF, rank_select_n);
        chk("rst_cke", 4'h0, rank_clk_en);
        reset = 1'b0;
        @(negedge core_clk);
        chk("clk_en", 4'hF, rank_clk_en);
        t_ranks();
        t_mask();
        t_miss();
        results();
    end
endmodule // drpm_rank_port_map_tb
bind drpm_rank_port_map drpm_rank_port_map_assertions #(
    .RANKS(RANKS),
    .MASK_W(MASK_W),
    .STROBE_W(STROBE_W)
) u_chk (
    .core_clk(core_clk),
    .reset(reset),
    .iface_req_valid(iface_req_valid),
    .iface_request_address(iface_request_address),
    .iface_req_ready(iface_req_ready),
    .iface_req_miss(iface_req_miss),
    .iface_read_valid(iface_read_valid),
    .rank_select_n(rank_select_n),
    .rank_clk_en(rank_clk_en),
    .rank_termination_ctl(rank_termination_ctl),
    .mem_write_en(mem_write_en),
    .mem_dq_oe(mem_dq_oe),
    .mem_mask_pins(mem_mask_pins),
    .mem_strobe_p_out(mem_strobe_p_out),
    .mem_strobe_n_out(mem_strobe_n_out)
);
`default_nettype wire
